// ---- rtl/cof_pkg.sv ----
// What this block does
// - overflow_flag is bit 63; the M, S, U, VS and VU count inhibits are bits 62 down to 58.
// - an inhibit bit whose privilege mode the hart lacks reads zero and ignores writes.
// - no counting in a mode whose inhibit is set; with all five inhibits zero every mode counts.
// - overflow_flag goes to one on counter overflow and stays one until software writes it.
// - overflow is the unsigned carry out of the implemented counter bits.
// - after overflow the counter wraps and keeps counting whatever the flag holds.
// - with supervisor mode present a 32-bit read-only summary at SUMMARY_ADDR mirrors each overflow_flag live; the overflow_summary port follows one clock behind.
// - an overflow raises a count-overflow request only when its overflow_flag was zero.
// - software writes to counters or event-control registers never produce an overflow.
// - the count-overflow interrupt uses pending and enable bit 13 in machine and supervisor.
// - each request sets count_overflow_irq_pending and the counter's overflow_flag.
// - the delegation bit decides whether the interrupt goes to supervisor or machine mode.
// - summary bits read freely in M, behind counter-enable in S, behind both in VS, else zero.
package cof_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 64;

    // register offsets, word index on the plain port
    localparam logic [7:0] EVT_BASE = 8'h00;
    localparam logic [7:0] CNT_BASE = 8'h20;
    localparam logic [7:0] SUMMARY_ADDR = 8'h40;
    localparam logic [7:0] IP_ADDR = 8'h41;
    localparam logic [7:0] IE_ADDR = 8'h42;
    localparam logic [7:0] DELEG_ADDR = 8'h43;
    localparam logic [7:0] MCOUNTEREN_ADDR = 8'h44;
    localparam logic [7:0] HCOUNTEREN_ADDR = 8'h45;
    localparam logic [7:0] STAT_ADDR = 8'h46;
    localparam logic [7:0] MASK_ADDR = 8'h47;

    // event-control field positions
    localparam int FLAG_BIT = 63;
    localparam int INH_HI = 62;
    localparam int INH_LO = 58;
    localparam int LCOF_BIT = 13;

    // counter index range
    localparam int FIRST_CNT = 3;
    localparam int LAST_CNT = 31;
    localparam int SUMMARY_W = 32;

    // reset values
    localparam logic [63:0] CNT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [4:0] INH_RESET = 5'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [31:0] CEN_RESET = 32'h0000_0000;

    // privilege encodings
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;

    // interrupt status layout
    localparam int STAT_W = 2;
    localparam int STAT_REQ_BIT = 0;
    localparam int STAT_MISSED_BIT = 1;

    typedef struct packed {
        logic virt;
        logic [1:0] priv;
    } cof_mode_t;

    // inh order: machine, supervisor, user, virt supervisor, virt user
    typedef struct packed {
        logic overflow_flag;
        logic [4:0] inh;
    } cof_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [63:0] wdata;
    } cof_bus_t;

endpackage

// ---- rtl/cof_counter_slice.sv ----
`timescale 1ns/100ps
module cof_counter_slice #(
    parameter int CNT_W = 64,
    parameter int EVSEL_W = 16,
    parameter logic [4:0] INH_MASK = 5'h1F
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core side
    input wire logic event_pulse,
    input wire cof_pkg::cof_mode_t mode,
    // software writes
    input wire logic evt_wr,
    input wire logic cnt_wr,
    input wire logic [63:0] wdata,
    // state out
    output logic [63:0] evt_value,
    output logic [63:0] cnt_value,
    output logic overflow_flag,
    output logic ovf_req,
    output logic ovf_missed
);

    cof_pkg::cof_flags_t flags;
    logic [CNT_W-1:0] cnt;
    logic [EVSEL_W-1:0] evsel;
    logic [CNT_W:0] sum;
    logic inhibited;
    logic incr;
    logic ovf;

    //////////////////////////////////////////////////////////////////////////////////////////
    // mode filter
    always_comb
    begin
        inhibited = 1'b0;
        if (mode.priv == cof_pkg::PRIV_M)
            inhibited = flags.inh[4];
        else if (mode.priv == cof_pkg::PRIV_S)
            inhibited = mode.virt ? flags.inh[1] : flags.inh[3];
        else if (mode.priv == cof_pkg::PRIV_U)
            inhibited = mode.virt ? flags.inh[0] : flags.inh[2];
    end

    assign incr = event_pulse && !inhibited && !cnt_wr;
    assign sum = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
    assign ovf = incr && sum[CNT_W];
    assign ovf_req = ovf && !flags.overflow_flag;
    assign ovf_missed = ovf && flags.overflow_flag;

    //////////////////////////////////////////////////////////////////////////////////////////
    // wrap and keep counting
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= cof_pkg::CNT_RESET[CNT_W-1:0];
        else if (cnt_wr)
            cnt <= wdata[CNT_W-1:0];
        else if (incr)
            cnt <= sum[CNT_W-1:0];
    end

    // sticky flag, set wins over write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags.overflow_flag <= cof_pkg::FLAG_RESET;
        else if (ovf)
            flags.overflow_flag <= 1'b1;
        else if (evt_wr)
            flags.overflow_flag <= wdata[cof_pkg::FLAG_BIT];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags.inh <= cof_pkg::INH_RESET;
        else if (evt_wr)
            flags.inh <= wdata[cof_pkg::INH_HI:cof_pkg::INH_LO] & INH_MASK;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            evsel <= '0;
        else if (evt_wr)
            evsel <= wdata[EVSEL_W-1:0];
    end

    assign evt_value = {flags.overflow_flag, flags.inh, {(cof_pkg::INH_LO - EVSEL_W){1'b0}}, evsel};
    assign cnt_value = 64'(cnt);
    assign overflow_flag = flags.overflow_flag;

endmodule // cof_counter_slice

// ---- rtl/cof_irq_status.sv ----
`timescale 1ns/100ps
module cof_irq_status #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and software access
    input wire logic [W-1:0] events,
    input wire logic stat_rd,
    input wire logic mask_wr,
    input wire logic [W-1:0] wdata,
    // state out
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    logic [W-1:0] next_status;
    logic [W-1:0] next_mask;

    // read clears, new event wins
    always_comb
    begin
        next_status = (status & ~{W{stat_rd}}) | events;
        next_mask = mask_wr ? wdata : mask;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            mask <= next_mask;
            irq <= |(next_status & next_mask);
        end
    end

endmodule // cof_irq_status

// ---- rtl/cof_overflow_filter.sv ----
`timescale 1ns/100ps
module cof_overflow_filter #(
    parameter int CNT_W = 64,
    parameter int EVSEL_W = 16,
    parameter bit HAS_S = 1'b1,
    parameter bit HAS_U = 1'b1,
    parameter bit HAS_H = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [7:0] csr_addr,
    input wire logic [63:0] csr_wdata,
    input wire logic csr_wr,
    input wire logic csr_rd,
    output logic [63:0] csr_rdata,
    // core side
    input wire logic [31:0] cnt_event,
    input wire logic [1:0] priv_mode,
    input wire logic virt_mode,
    // hart interrupt logic
    output logic count_overflow_irq_pending,
    output logic count_overflow_irq_enable,
    output logic count_overflow_to_supervisor,
    output logic [31:0] overflow_summary,
    // block interrupt
    output logic irq
);

    localparam logic [4:0] INH_MASK = {1'b1, HAS_S, HAS_U, HAS_H & HAS_S, HAS_H & HAS_U};

    logic rst_meta;
    logic rst_n;
    cof_pkg::cof_bus_t bus;
    cof_pkg::cof_mode_t mode;
    logic [63:0] evt_val [32];
    logic [63:0] cnt_val [32];
    logic [31:0] of_vec;
    logic [31:0] req_vec;
    logic [31:0] missed_vec;
    logic req_any;
    logic [31:0] mcounteren;
    logic [31:0] hcounteren;
    logic [31:0] summary_view;
    logic [cof_pkg::STAT_W-1:0] stat;
    logic [cof_pkg::STAT_W-1:0] stat_mask;
    logic [cof_pkg::STAT_W-1:0] stat_events;
    logic stat_rd;
    logic [63:0] next_rdata;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
        in_bank = (addr >= base + 8'(cof_pkg::FIRST_CNT)) && (addr <= base + 8'(cof_pkg::LAST_CNT));
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign bus = '{wr: csr_wr, rd: csr_rd, addr: csr_addr, wdata: csr_wdata};
    assign mode = '{virt: virt_mode, priv: priv_mode};

    //////////////////////////////////////////////////////////////////////////////////////////
    // counter slices
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_cnt
            if (i >= cof_pkg::FIRST_CNT && i <= cof_pkg::LAST_CNT)
            begin : g_on
                cof_counter_slice #(
                    .CNT_W(CNT_W),
                    .EVSEL_W(EVSEL_W),
                    .INH_MASK(INH_MASK)
                ) u_slice (
                    .clk(clk_sys),
                    .rst_n(rst_n),
                    .event_pulse(cnt_event[i]),
                    .mode(mode),
                    .evt_wr(bus.wr && hit(bus.addr, cof_pkg::EVT_BASE + 8'(i))),
                    .cnt_wr(bus.wr && hit(bus.addr, cof_pkg::CNT_BASE + 8'(i))),
                    .wdata(bus.wdata),
                    .evt_value(evt_val[i]),
                    .cnt_value(cnt_val[i]),
                    .overflow_flag(of_vec[i]),
                    .ovf_req(req_vec[i]),
                    .ovf_missed(missed_vec[i])
                );
            end
            else
            begin : g_off
                assign evt_val[i] = '0;
                assign cnt_val[i] = '0;
                assign of_vec[i] = 1'b0;
                assign req_vec[i] = 1'b0;
                assign missed_vec[i] = 1'b0;
            end
        end
    endgenerate

    assign req_any = |req_vec;

    //////////////////////////////////////////////////////////////////////////////////////////
    // request sets pending
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_overflow_irq_pending <= 1'b0;
        else if (req_any)
            count_overflow_irq_pending <= 1'b1;
        else if (bus.wr && hit(bus.addr, cof_pkg::IP_ADDR))
            count_overflow_irq_pending <= bus.wdata[cof_pkg::LCOF_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_overflow_irq_enable <= 1'b0;
        else if (bus.wr && hit(bus.addr, cof_pkg::IE_ADDR))
            count_overflow_irq_enable <= bus.wdata[cof_pkg::LCOF_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_overflow_to_supervisor <= 1'b0;
        else if (bus.wr && hit(bus.addr, cof_pkg::DELEG_ADDR))
            count_overflow_to_supervisor <= HAS_S & bus.wdata[cof_pkg::LCOF_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mcounteren <= cof_pkg::CEN_RESET;
            hcounteren <= cof_pkg::CEN_RESET;
        end
        else
        begin
            if (bus.wr && hit(bus.addr, cof_pkg::MCOUNTEREN_ADDR))
                mcounteren <= bus.wdata[31:0];
            if (bus.wr && hit(bus.addr, cof_pkg::HCOUNTEREN_ADDR))
                hcounteren <= HAS_H ? bus.wdata[31:0] : cof_pkg::CEN_RESET;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // registered shadow of flags, one clock behind
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            overflow_summary <= '0;
        else
            overflow_summary <= HAS_S ? of_vec : '0;
    end

    always_comb
    begin
        summary_view = '0;
        if (HAS_S)
        begin
            if (mode.priv == cof_pkg::PRIV_M)
                summary_view = of_vec;
            else if (mode.priv == cof_pkg::PRIV_S && !mode.virt)
                summary_view = of_vec & mcounteren;
            else if (mode.priv == cof_pkg::PRIV_S && mode.virt)
                summary_view = of_vec & mcounteren & hcounteren;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // event status and interrupt
    assign stat_events = {|missed_vec, req_any};
    assign stat_rd = bus.rd && hit(bus.addr, cof_pkg::STAT_ADDR);

    cof_irq_status #(
        .W(cof_pkg::STAT_W)
    ) u_irq (
        .clk(clk_sys),
        .rst_n(rst_n),
        .events(stat_events),
        .stat_rd(stat_rd),
        .mask_wr(bus.wr && hit(bus.addr, cof_pkg::MASK_ADDR)),
        .wdata(bus.wdata[cof_pkg::STAT_W-1:0]),
        .status(stat),
        .mask(stat_mask),
        .irq()
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(((stat & ~{cof_pkg::STAT_W{stat_rd}}) | stat_events) & stat_mask);
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb
    begin
        next_rdata = '0;
        if (in_bank(bus.addr, cof_pkg::EVT_BASE))
            next_rdata = evt_val[bus.addr[4:0]];
        else if (in_bank(bus.addr, cof_pkg::CNT_BASE))
            next_rdata = cnt_val[bus.addr[4:0]];
        else if (hit(bus.addr, cof_pkg::SUMMARY_ADDR))
            next_rdata = 64'(summary_view);
        else if (hit(bus.addr, cof_pkg::IP_ADDR))
            next_rdata = 64'(count_overflow_irq_pending) << cof_pkg::LCOF_BIT;
        else if (hit(bus.addr, cof_pkg::IE_ADDR))
            next_rdata = 64'(count_overflow_irq_enable) << cof_pkg::LCOF_BIT;
        else if (hit(bus.addr, cof_pkg::DELEG_ADDR))
            next_rdata = 64'(count_overflow_to_supervisor) << cof_pkg::LCOF_BIT;
        else if (hit(bus.addr, cof_pkg::MCOUNTEREN_ADDR))
            next_rdata = 64'(mcounteren);
        else if (hit(bus.addr, cof_pkg::HCOUNTEREN_ADDR))
            next_rdata = 64'(hcounteren);
        else if (hit(bus.addr, cof_pkg::STAT_ADDR))
            next_rdata = 64'(stat);
        else if (hit(bus.addr, cof_pkg::MASK_ADDR))
            next_rdata = 64'(stat_mask);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            csr_rdata <= '0;
        else if (bus.rd)
            csr_rdata <= next_rdata;
        else
            csr_rdata <= '0;
    end

endmodule // cof_overflow_filter

// ---- dv/cof_core_model.sv ----
`timescale 1ns/100ps
module cof_core_model (
    // clock
    input wire logic clk_sys,
    // bench commands
    input wire logic ev_go,
    input wire logic [4:0] ev_idx,
    input wire cof_pkg::cof_mode_t ev_mode,
    // core outputs
    output logic [31:0] cnt_event,
    output logic [1:0] priv_mode,
    output logic virt_mode
);
    always @(posedge clk_sys)
    begin
        cnt_event <= ev_go ? (32'h1 << ev_idx) : 32'h0;
        priv_mode <= ev_mode.priv;
        virt_mode <= ev_mode.virt;
    end
endmodule // cof_core_model

// ---- dv/cof_overflow_filter_properties.sv ----
`timescale 1ns/100ps
module cof_overflow_filter_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire logic [7:0] csr_addr,
    input wire logic [63:0] csr_wdata,
    input wire logic csr_wr,
    input wire logic csr_rd,
    input wire logic [63:0] csr_rdata,
    // core side
    input wire logic [31:0] cnt_event,
    input wire logic [1:0] priv_mode,
    input wire logic virt_mode,
    // interrupt side
    input wire logic count_overflow_irq_pending,
    input wire logic count_overflow_irq_enable,
    input wire logic count_overflow_to_supervisor,
    input wire logic [31:0] overflow_summary,
    input wire logic irq
);
    wire pend = count_overflow_irq_pending;
    wire ev = |cnt_event[31:3];
    wire w_ip = csr_wr && csr_addr == cof_pkg::IP_ADDR;
    wire w_ie = csr_wr && csr_addr == cof_pkg::IE_ADDR;
    wire w_dl = csr_wr && csr_addr == cof_pkg::DELEG_ADDR;
    wire r_sum = csr_rd && csr_addr == cof_pkg::SUMMARY_ADDR;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    pend_hold_a: assert property (pend && !w_ip |=> pend)
        else $error("pending dropped");
    pend_cause_a: assert property ($rose(pend) |-> $past(w_ip || ev))
        else $error("pending without cause");
    pend_clear_a: assert property (w_ip && !csr_wdata[13] && !ev |=> !pend)
        else $error("pending not cleared");
    en_load_a: assert property (w_ie |=> count_overflow_irq_enable == $past(csr_wdata[13]))
        else $error("enable not loaded");
    en_keep_a: assert property (!w_ie |=> $stable(count_overflow_irq_enable))
        else $error("enable moved");
    deleg_load_a: assert property (
        w_dl |=> count_overflow_to_supervisor == $past(csr_wdata[13]))
        else $error("delegation not loaded");
    sum_cause_a: assert property ($changed(overflow_summary) |-> $past(ev || csr_wr, 2))
        else $error("summary moved alone");
    sum_user_a: assert property (
        $past(r_sum && priv_mode == cof_pkg::PRIV_U) |-> csr_rdata == 64'h0)
        else $error("summary seen in user mode");
    irq_cause_a: assert property ($rose(irq) |-> $past(ev) || $past(csr_wr, 2))
        else $error("irq without cause");
endmodule // cof_overflow_filter_chk

bind cof_overflow_filter cof_overflow_filter_chk u_chk (
    .clk_sys, .resetn, .csr_addr, .csr_wdata, .csr_wr, .csr_rd, .csr_rdata,
    .cnt_event, .priv_mode, .virt_mode, .count_overflow_irq_pending,
    .count_overflow_irq_enable, .count_overflow_to_supervisor, .overflow_summary, .irq
);

// ---- dv/cof_overflow_filter_tb_top.sv ----
`timescale 1ns/100ps
module cof_overflow_filter_tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic csr_wr = 1'b0;
    logic csr_rd = 1'b0;
    logic ev_go = 1'b0;
    logic [4:0] ev_idx = 5'h00;
    logic [7:0] csr_addr = 8'h00;
    logic [63:0] csr_wdata = 64'h0;
    logic [63:0] csr_rdata;
    logic [31:0] cnt_event, overflow_summary;
    logic [1:0] priv_mode;
    logic virt_mode, irq, count_overflow_irq_pending, count_overflow_irq_enable;
    logic count_overflow_to_supervisor;
    cof_pkg::cof_mode_t ev_mode = 3'h3;
    cof_pkg::cof_mode_t md [5] = '{3'h3, 3'h1, 3'h0, 3'h5, 3'h4};
    int fails = 0;
    int checks = 0;

    initial forever #4 clk_sys = ~clk_sys;

    cof_core_model core (.clk_sys, .ev_go, .ev_idx, .ev_mode, .cnt_event, .priv_mode,
        .virt_mode);
    cof_overflow_filter DUT (.clk_sys, .resetn, .csr_addr, .csr_wdata, .csr_wr, .csr_rd,
        .csr_rdata, .cnt_event, .priv_mode, .virt_mode, .count_overflow_irq_pending,
        .count_overflow_irq_enable, .count_overflow_to_supervisor, .overflow_summary, .irq);
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk_sys);
        csr_wr <= 1'b1;
        csr_addr <= a;
        csr_wdata <= d;
        @(posedge clk_sys);
        csr_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [63:0] e);
        @(posedge clk_sys);
        csr_rd <= 1'b1;
        csr_addr <= a;
        @(posedge clk_sys);
        csr_rd <= 1'b0;
        #1;
        chk(nm, e, csr_rdata);
    endtask
    task automatic ev(input logic [4:0] i, input cof_pkg::cof_mode_t m);
        @(posedge clk_sys);
        ev_go <= 1'b1;
        ev_idx <= i;
        ev_mode <= m;
        @(posedge clk_sys);
        ev_go <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic setm(input cof_pkg::cof_mode_t m);
        @(posedge clk_sys);
        ev_mode <= m;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rdc("evt3", cof_pkg::EVT_BASE + 8'h03, 64'h0);
        rdc("unmapped", 8'hFF, 64'h0);
        wr(cof_pkg::SUMMARY_ADDR, 64'hFFFF_FFFF);
        rdc("summary", cof_pkg::SUMMARY_ADDR, 64'h0);
        wr(cof_pkg::EVT_BASE + 8'h05, 64'hFC00_0000_0000_00AB);
        rdc("evt5", cof_pkg::EVT_BASE + 8'h05, 64'hFC00_0000_0000_00AB);
        rdc("pend", cof_pkg::IP_ADDR, 64'h0);
        wr(cof_pkg::EVT_BASE + 8'h05, 64'h0);
        rdc("evt5 clr", cof_pkg::EVT_BASE + 8'h05, 64'h0);
    endtask
    task automatic t_inhibit();
        for (int i = 0; i < 5; i++)
        begin
            wr(cof_pkg::EVT_BASE + 8'h04, 64'h4000_0000_0000_0000 >> i);
            wr(cof_pkg::CNT_BASE + 8'h04, 64'h0);
            ev(5'h04, md[i]);
            ev(5'h04, md[(i + 1) % 5]);
            rdc("inhibit", cof_pkg::CNT_BASE + 8'h04, 64'h1);
        end
        wr(cof_pkg::EVT_BASE + 8'h04, 64'h0);
        for (int i = 0; i < 5; i++)
            ev(5'h04, md[i]);
        rdc("all modes", cof_pkg::CNT_BASE + 8'h04, 64'h6);
    endtask
    task automatic t_ovf();
        wr(cof_pkg::MASK_ADDR, 64'h3);
        wr(cof_pkg::CNT_BASE + 8'h03, 64'hFFFF_FFFF_FFFF_FFFF);
        rdc("no pend", cof_pkg::IP_ADDR, 64'h0);
        ev(5'h03, md[0]);
        rdc("wrap", cof_pkg::CNT_BASE + 8'h03, 64'h0);
        rdc("flag", cof_pkg::EVT_BASE + 8'h03, 64'h8000_0000_0000_0000);
        chk("summary", 64'h8, {32'h0, overflow_summary});
        chk("irq", 64'h1, {63'h0, irq});
        rdc("status", cof_pkg::STAT_ADDR, 64'h1);
        chk("irq clr", 64'h0, {63'h0, irq});
        chk("pend pin", 64'h1, {63'h0, count_overflow_irq_pending});
        wr(cof_pkg::EVT_BASE + 8'h03, 64'h0);
        rdc("pend kept", cof_pkg::IP_ADDR, 64'h2000);
        wr(cof_pkg::IP_ADDR, 64'h0);
        rdc("pend clr", cof_pkg::IP_ADDR, 64'h0);
        wr(cof_pkg::MASK_ADDR, 64'h0);
        wr(cof_pkg::CNT_BASE + 8'h03, 64'hFFFF_FFFF_FFFF_FFFF);
        wr(cof_pkg::EVT_BASE + 8'h03, 64'h8000_0000_0000_0000);
        ev(5'h03, md[0]);
        rdc("no req", cof_pkg::IP_ADDR, 64'h0);
        chk("irq masked", 64'h0, {63'h0, irq});
        rdc("status2", cof_pkg::STAT_ADDR, 64'h2);
        rdc("wrap2", cof_pkg::CNT_BASE + 8'h03, 64'h0);
    endtask
    task automatic t_ctrl();
        wr(cof_pkg::IE_ADDR, 64'h2000);
        chk("enable", 64'h1, {63'h0, count_overflow_irq_enable});
        wr(cof_pkg::DELEG_ADDR, 64'h2000);
        chk("deleg", 64'h1, {63'h0, count_overflow_to_supervisor});
        wr(cof_pkg::IE_ADDR, 64'h0);
        rdc("ie off", cof_pkg::IE_ADDR, 64'h0);
        wr(cof_pkg::DELEG_ADDR, 64'h0);
    endtask
    task automatic t_summary();
        setm(md[1]);
        rdc("s closed", cof_pkg::SUMMARY_ADDR, 64'h0);
        wr(cof_pkg::MCOUNTEREN_ADDR, 64'h8);
        rdc("s open", cof_pkg::SUMMARY_ADDR, 64'h8);
        setm(md[3]);
        rdc("vs closed", cof_pkg::SUMMARY_ADDR, 64'h0);
        wr(cof_pkg::HCOUNTEREN_ADDR, 64'h8);
        rdc("vs open", cof_pkg::SUMMARY_ADDR, 64'h8);
        setm(md[2]);
        rdc("u", cof_pkg::SUMMARY_ADDR, 64'h0);
        setm(md[0]);
        wr(cof_pkg::MCOUNTEREN_ADDR, 64'h0);
        rdc("m", cof_pkg::SUMMARY_ADDR, 64'h8);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_inhibit();
        t_ovf();
        t_ctrl();
        t_summary();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        conclude();
    end
endmodule // cof_overflow_filter_tb_top
